// *** verif/amr_ctrl_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module amr_ctrl_bench
  import amr_pkg::*;
;
  localparam int POR_T = 20;
  localparam int MOD_T = 2;
  localparam int OSR_T = 32;
  localparam int LIMIT = 40000;
  logic clk_in = 1'b0;
  logic clk_run = 1'b1;
  logic nrst_in;
  amr_bus_t bus;
  logic [15:0] rdata;
  amr_ser_t ser;
  logic sync_n;
  logic cd_v;
  logic [NCH-1:0][23:0] cd_res;
  logic flag_n, strobe, fast, swap, pcal, tblk, stby, cda;
  logic [NCH-1:0] chen;
  amr_pwr_t pwr;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  logic sw0;
  amr_ctrl #(.POR_CYCLES(POR_T), .MOD_DIV(MOD_T), .OVERSAMPLING_RATIO(OSR_T)) DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus), .rdata_out(rdata), .ser_in(ser),
    .sync_rst_n_in(sync_n), .cd_res_valid_in(cd_v), .cd_res_in(cd_res),
    .new_result_flag_n_out(flag_n), .result_strobe_out(strobe), .fast_filter_out(fast),
    .swap_polarity_out(swap), .phase_cal_off_out(pcal), .test_sig_block_out(tblk),
    .standby_out(stby), .cd_active_out(cda), .channel_enable_out(chen),
    .power_level_out(pwr));
  amr_host_model host (.clk_in(clk_in), .ser_out(ser), .sync_rst_n_out(sync_n));
  always #12.5 if (clk_run) clk_in = ~clk_in;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
    @(posedge clk_in);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus.rd <= 1'b0;
    @(negedge clk_in);
    chk(name, exp, rdata);
  endtask
  // counts cycles to the next result, bounded
  task automatic wait_strobe(output int k);
    k = 0;
    do
    begin
      @(negedge clk_in);
      k++;
    end
    while (strobe !== 1'b1 && k < 3000);
  endtask
  task automatic feed(input logic [23:0] c0, input logic [23:0] c1);
    @(posedge clk_in);
    cd_res[0] <= c0;
    cd_res[1] <= c1;
    cd_v <= 1'b1;
    @(posedge clk_in);
    cd_v <= 1'b0;
    repeat (5) @(negedge clk_in);
  endtask
  // hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      err_total++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    nrst_in = 1'b0;
    bus = '0;
    cd_v = 1'b0;
    cd_res = '0;
    repeat (3) @(posedge clk_in);
    nrst_in <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (flag_n !== 1'b1 && n < 200);
    chk("flag_ready", 16'h0001, 16'(flag_n));
    chk("por_long", 16'h0001, 16'(n >= POR_T));
    chk("fast_start", 16'h0001, 16'(fast));
    rd(REG_CLOCK, CLOCK_RST, "clock_dflt");
    rd(REG_CFG, CFG_RST, "cfg_dflt");
    rd(REG_THR_UP, THR_RST[23:8], "thr_up_dflt");
    rd(4'hF, 16'h0000, "unmapped");
    chk("chan_dflt", 16'h003F, 16'(chen));
    wait_strobe(n);
    wait_strobe(n);
    chk("cont_period", 16'(OSR_T * MOD_T), 16'(n));
    repeat (2) @(negedge clk_in);
    chk("fast_off", 16'h0000, 16'(fast));
    for (int p = 0; p < 4; p++)
    begin
      wr(REG_CLOCK, 16'h003F | 16'(p << 8));
      @(negedge clk_in);
      chk("power", (p == 0) ? 16'(PWR_VLP) : (p == 1) ? 16'(PWR_LP) : 16'(PWR_HR),
          16'(pwr));
    end
    // chop with delay code 1: 4 modulator periods plus three ratios
    wr(REG_CFG, 16'h0011);
    wait_strobe(n);
    wait_strobe(n);
    chk("chop_period", 16'(4 * MOD_T + 3 * OSR_T * MOD_T), 16'(n));
    @(negedge clk_in);
    sw0 = swap;
    wait_strobe(n);
    @(negedge clk_in);
    chk("swap", 16'(!sw0), 16'(swap));
    chk("chop_ctrl", 16'h0001, 16'(pcal & tblk));
    // detect setup: ch0 only, threshold 0001AB, 128 samples, two hits
    wr(REG_CLOCK, 16'h0201);
    wr(REG_THR_UP, 16'h0001);
    wr(REG_THR_LO, 16'hFFAB);
    rd(REG_THR_LO, 16'h00AB, "thr_lo");
    wr(REG_CFG, 16'h1020);
    host.frame(CMD_STANDBY, FRAME_WORDS);
    repeat (10) @(negedge clk_in);
    chk("stby_on", 16'h0001, 16'(stby));
    // master clock stopped off-grid, resumes in phase
    clk_run = 1'b0;
    #1005;
    clk_run = 1'b1;
    repeat (2) @(negedge clk_in);
    chk("stby_parked", 16'h0001, 16'(stby));
    host.line_low(20);
    chk("cd_on", 16'h0001, 16'(cda));
    repeat (3) feed(24'h000000, 24'h7FFFFF);
    chk("cd_masked", 16'h0001, 16'(cda));
    feed(24'hFFFE00, 24'h000000);
    chk("cd_one_hit", 16'h0001, 16'(cda));
    feed(24'hFFFE00, 24'h000000);
    n = 0;
    while (cda !== 1'b0 && n < 50)
    begin
      @(negedge clk_in);
      n++;
    end
    chk("cd_flag", 16'h0000, 16'(flag_n));
    chk("cd_back", 16'h0001, 16'(stby));
    // all-channels: one channel alone must not notify
    wr(REG_CLOCK, 16'h0203);
    wr(REG_CFG, 16'h1060);
    host.line_low(20);
    repeat (2) feed(24'hFFFE00, 24'h000000);
    chk("cd_all_wait", 16'h0001, 16'(cda));
    repeat (2) feed(24'h000000, 24'h000200);
    chk("cd_all_hit", 16'h0000, 16'(cda));
    wr(REG_CFG, 16'h1020);
    // cut frame leaves the device alone
    host.frame(CMD_RESET, 7);
    repeat (10) @(negedge clk_in);
    chk("cut_frame", 16'h0001, 16'(stby));
    host.frame(CMD_WAKEUP, FRAME_WORDS);
    repeat (10) @(negedge clk_in);
    chk("wake", 16'h0000, 16'(stby));
    rd(REG_CFG, 16'h1020, "cfg_kept");
    host.frame(CMD_STANDBY, FRAME_WORDS);
    host.frame(CMD_RESET, FRAME_WORDS);
    chk("cmd_reset", 16'h0000, 16'(stby));
    rd(REG_CFG, CFG_RST, "cfg_cmd_rst");
    host.frame(CMD_STANDBY, FRAME_WORDS);
    wr(REG_CFG, 16'h1020);
    host.line_low(120);
    rd(REG_CFG, CFG_RST, "cfg_pin_rst");
    chk("pin_run", 16'h0000, 16'(stby));
    print_verdict();
  end
endmodule // amr_ctrl_bench
`default_nettype wire

// *** verif/amr_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module amr_ctrl_props
  import amr_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int MOD_DIV = 2,
  parameter int OVERSAMPLING_RATIO = 1024
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // register port
  input wire amr_bus_t bus_in,
  input wire logic [15:0] rdata_out,
  // pins and detect results
  input wire amr_ser_t ser_in,
  input wire logic sync_rst_n_in,
  input wire logic cd_res_valid_in,
  input wire logic [NCH-1:0][23:0] cd_res_in,
  // watched outputs
  input wire logic new_result_flag_n_out,
  input wire logic result_strobe_out,
  input wire logic fast_filter_out,
  input wire logic swap_polarity_out,
  input wire logic phase_cal_off_out,
  input wire logic test_sig_block_out,
  input wire logic standby_out,
  input wire logic cd_active_out,
  input wire logic [NCH-1:0] channel_enable_out,
  input wire amr_pwr_t power_level_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // cycles the reset line has stayed low, saturating
  logic [7:0] low_cnt_r;
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in) low_cnt_r <= 8'h00;
    else if (sync_rst_n_in) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  // a result pulse left alone by standby or pin reset
  sequence undisturbed_pulse;
    result_strobe_out ##1 (!standby_out && sync_rst_n_in) [*7];
  endsequence
  flag_por_a: assert property (
    $rose(nrst_in) |-> !new_result_flag_n_out [*8])
    else $error("flag left low too briefly after power-on");
  rdata_idle_a: assert property (
    !bus_in.rd |=> rdata_out == 16'h0000)
    else $error("read data not zero outside read answer");
  strobe_flag_a: assert property (
    result_strobe_out |-> $fell(new_result_flag_n_out))
    else $error("result without flag falling edge");
  flag_hold_a: assert property (
    undisturbed_pulse |-> !new_result_flag_n_out)
    else $error("flag pulse ended too early");
  result_gap_a: assert property (
    result_strobe_out && !phase_cal_off_out |=> !result_strobe_out [*8])
    else $error("results too close together");
  chop_tie_a: assert property (
    phase_cal_off_out == test_sig_block_out)
    else $error("phase and test blocking disagree");
  swap_chop_a: assert property (
    phase_cal_off_out && result_strobe_out |-> ##[0:1] $changed(swap_polarity_out))
    else $error("polarity not swapped after chop sample");
  fast_done_a: assert property (
    $fell(fast_filter_out) |-> result_strobe_out || $past(result_strobe_out) || phase_cal_off_out)
    else $error("fast filter left without a result");
  stby_chan_a: assert property (
    standby_out |-> channel_enable_out == 6'h00 && !result_strobe_out)
    else $error("channels active in standby");
  cd_entry_a: assert property (
    $rose(cd_active_out) |-> $past(standby_out))
    else $error("detect entered from outside standby");
  cd_stby_a: assert property (
    cd_active_out |-> standby_out)
    else $error("detect mode without standby level");
  pin_hold_a: assert property (
    low_cnt_r > 8'h64 |-> channel_enable_out == 6'h00 && !standby_out)
    else $error("device not held in pin reset");
endmodule // amr_ctrl_props
bind amr_ctrl amr_ctrl_props #(.POR_CYCLES(POR_CYCLES), .MOD_DIV(MOD_DIV), .OVERSAMPLING_RATIO(OVERSAMPLING_RATIO)) u_props (
  .clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .ser_in(ser_in), .sync_rst_n_in(sync_rst_n_in), .cd_res_valid_in(cd_res_valid_in),
  .cd_res_in(cd_res_in), .new_result_flag_n_out(new_result_flag_n_out),
  .result_strobe_out(result_strobe_out), .fast_filter_out(fast_filter_out),
  .swap_polarity_out(swap_polarity_out), .phase_cal_off_out(phase_cal_off_out),
  .test_sig_block_out(test_sig_block_out), .standby_out(standby_out),
  .cd_active_out(cd_active_out), .channel_enable_out(channel_enable_out),
  .power_level_out(power_level_out));
`default_nettype wire

// *** verif/amr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module amr_host_model
  import amr_pkg::*;
#(
  parameter int LOAD_CYC = 16
)
(
  // master clock, for reset line timing and the settle wait after a reset command
  input wire logic clk_in,
  // serial pins and reset line
  output var amr_ser_t ser_out,
  output var logic sync_rst_n_out
);
  // idle: deselected, serial clock parked low
  initial
  begin
    ser_out = '{cs_n: 1'b1, sclk: 1'b0, din: 1'b1};
    sync_rst_n_out = 1'b1;
  end
  // one frame, command in word 0, rest zero; 200 ns bit time, own phase
  // whole frame unless cut
  task automatic frame(input logic [15:0] cmd, input int words);
    logic [191:0] bits;
    bits = {cmd, 176'h0};
    #37;
    ser_out.cs_n = 1'b0;
    for (int i = 0; i < words * 24; i++)
    begin
      #100;
      ser_out.sclk = 1'b1;
      ser_out.din = bits[191 - i];
      #100;
      ser_out.sclk = 1'b0;
    end
    #100;
    ser_out.cs_n = 1'b1;
    // released data line must not look like a held bit
    ser_out.din = ~ser_out.din;
    if (cmd == CMD_RESET && words == FRAME_WORDS)
      repeat (LOAD_CYC) @(posedge clk_in);
  endtask
  // low pulse on the reset line, short or long
  // pulse then settle
  task automatic line_low(input int cyc);
    @(posedge clk_in);
    sync_rst_n_out <= 1'b0;
    repeat (cyc) @(posedge clk_in);
    sync_rst_n_out <= 1'b1;
    repeat (LOAD_CYC) @(posedge clk_in);
  endtask
endmodule // amr_host_model
`default_nettype wire

// *** verilog/amr_ctrl.sv ***
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module amr_ctrl
  import amr_pkg::*;
#(
  parameter int POR_CYCLES = POR_CYC,
  parameter int MOD_DIV = 2,
  parameter int OVERSAMPLING_RATIO = 1024
)
(
  // clock and power-on reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // register port
  input wire amr_bus_t bus_in,
  output logic [15:0] rdata_out,
  // serial pins and reset line
  input wire amr_ser_t ser_in,
  input wire logic sync_rst_n_in,
  // internal detect converter results
  input wire logic cd_res_valid_in,
  input wire logic [NCH-1:0][23:0] cd_res_in,
  // flag pin and converter controls
  output logic new_result_flag_n_out,
  output logic result_strobe_out,
  output logic fast_filter_out,
  output logic swap_polarity_out,
  output logic phase_cal_off_out,
  output logic test_sig_block_out,
  output logic standby_out,
  output logic cd_active_out,
  output logic [NCH-1:0] channel_enable_out,
  output amr_pwr_t power_level_out
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    amr_state_t st;
    logic [3:0] sy1; // sync stage one
    logic [3:0] sy2; // sync stage two
    logic sclk_d; // previous sclk level
    logic [4:0] bitcnt;
    logic [3:0] wordcnt;
    logic [23:0] shreg;
    logic [15:0] cmd;
    logic [15:0] rsl_cnt; // reset-line low time
    logic [31:0] por_cnt;
    logic [15:0] clock_reg;
    logic [15:0] cfg_reg;
    logic [23:0] thr_reg;
    logic [15:0] rdata;
    logic [7:0] mdiv;
    logic [19:0] pcnt; // modulator periods in phase
    logic settle; // chop settle phase
    logic [1:0] nres; // results since reset
    logic [7:0] flag_cnt;
    logic flag_n;
    logic swap;
    logic strobe;
    logic [11:0] cd_samp;
    logic [NCH-1:0][7:0] cd_hits;
  } amr_reg_t;

  amr_reg_t r_r;
  amr_reg_t r_nxt;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin : next_p
    logic fall; // sclk falling edge
    logic cs_hi;
    logic frame_done;
    logic do_reset;
    logic mtick;
    logic gc_on;
    logic [19:0] target;
    logic [19:0] dly;
    logic det;
    logic [NCH-1:0] met;
    logic [NCH-1:0] en;
    logic [23:0] mag;
    logic [7:0] need;
    fall = 1'b0;
    cs_hi = 1'b0;
    frame_done = 1'b0;
    do_reset = 1'b0;
    mtick = 1'b0;
    gc_on = 1'b0;
    target = 20'h00000;
    dly = 20'h00000;
    det = 1'b0;
    met = '0;
    en = '0;
    mag = 24'h000000;
    need = 8'h00;
    r_nxt = r_r;
    // two-stage sync of pins
    r_nxt.sy1 = {ser_in.cs_n, ser_in.sclk, ser_in.din, sync_rst_n_in};
    r_nxt.sy2 = r_r.sy1;
    r_nxt.sclk_d = r_r.sy2[2];
    r_nxt.strobe = 1'b0;
    cs_hi = r_r.sy2[3];
    fall = r_r.sclk_d & ~r_r.sy2[2];
    en = r_r.clock_reg[NCH-1:0];
    gc_on = r_r.cfg_reg[CFG_GC_EN];

    // ---- serial receiver ----
    // clear on deselect
    if (cs_hi)
    begin
      r_nxt.bitcnt = 5'h00;
      r_nxt.wordcnt = 4'h0;
    end
    else if (fall && r_r.st != ST_POR && r_r.st != ST_PINRST)
    begin
      r_nxt.shreg = {r_r.shreg[22:0], r_r.sy2[1]};
      r_nxt.bitcnt = r_r.bitcnt + 5'h01;
      if (r_r.bitcnt == 5'(WORD_BITS - 1))
      begin
        r_nxt.bitcnt = 5'h00;
        // command sits in top of first word
        if (r_r.wordcnt == 4'h0)
        begin
          r_nxt.cmd = r_nxt.shreg[23:8];
        end
        if (r_r.wordcnt != 4'hF)
        begin
          r_nxt.wordcnt = r_r.wordcnt + 4'h1;
        end
        if (r_r.wordcnt == 4'(FRAME_WORDS - 1))
        begin
          frame_done = 1'b1;
        end
      end
    end

    // ---- commands ----
    if (frame_done)
    begin
      if (r_r.cmd == CMD_RESET)
      begin
        do_reset = 1'b1;
      end
      else if (r_r.cmd == CMD_STANDBY && r_r.st == ST_RUN)
      begin
        r_nxt.st = ST_STBY;
      end
      else if (r_r.cmd == CMD_WAKEUP && (r_r.st == ST_STBY || r_r.st == ST_CD))
      begin
        r_nxt.st = ST_RUN;
        r_nxt.pcnt = 20'h00000;
        r_nxt.settle = 1'b0;
      end
    end

    // ---- reset line ----
    if (!r_r.sy2[0])
    begin
      if (r_r.rsl_cnt != 16'hFFFF)
      begin
        r_nxt.rsl_cnt = r_r.rsl_cnt + 16'h0001;
      end
      if (r_r.rsl_cnt >= 16'(RSL_CYC) && r_r.st != ST_POR)
      begin
        r_nxt.st = ST_PINRST;
        do_reset = 1'b1;
      end
    end
    else
    begin
      r_nxt.rsl_cnt = 16'h0000;
      if (r_r.rsl_cnt != 16'h0000 && r_r.rsl_cnt < 16'(RSL_CYC) && r_r.st == ST_STBY
          && r_r.cfg_reg[CFG_DETECT_MODE_ENABLE])
      begin
        r_nxt.st = ST_CD;
        r_nxt.cd_samp = 12'h000;
        r_nxt.cd_hits = '0;
      end
      if (r_r.st == ST_PINRST)
      begin
        r_nxt.st = ST_RUN;
      end
    end

    // ---- power-on settle ----
    if (r_r.st == ST_POR)
    begin
      r_nxt.flag_n = 1'b0;
      if (r_r.por_cnt >= 32'(POR_CYCLES - 1))
      begin
        r_nxt.st = ST_RUN;
        r_nxt.flag_n = 1'b1;
      end
      else
      begin
        r_nxt.por_cnt = r_r.por_cnt + 32'h00000001;
      end
    end

    // ---- conversion timing ----
    if (r_r.st == ST_RUN)
    begin
      r_nxt.mdiv = r_r.mdiv + 8'h01;
      if (r_r.mdiv >= 8'(MOD_DIV - 1))
      begin
        r_nxt.mdiv = 8'h00;
        mtick = 1'b1;
      end
      // shift count kept five bits wide: code 15 must not wrap to zero
      // delay two to code plus one
      dly = 20'h00001 << ({1'b0, r_r.cfg_reg[3:0]} + 5'h01);
      if (gc_on)
      begin
        target = r_r.settle ? dly : 20'(3 * OVERSAMPLING_RATIO);
      end
      else
      begin
        target = 20'(OVERSAMPLING_RATIO);
      end
      if (mtick)
      begin
        r_nxt.pcnt = r_r.pcnt + 20'h00001;
        if (r_r.pcnt >= target - 20'h00001)
        begin
          r_nxt.pcnt = 20'h00000;
          if (gc_on && r_r.settle)
          begin
            r_nxt.settle = 1'b0;
          end
          else
          begin
            r_nxt.strobe = 1'b1;
            if (r_r.nres != 2'h2)
            begin
              r_nxt.nres = r_r.nres + 2'h1;
            end
            if (gc_on)
            begin
              r_nxt.swap = ~r_r.swap;
              r_nxt.settle = 1'b1;
            end
          end
        end
      end
    end
    else
    begin
      r_nxt.mdiv = 8'h00;
    end

    // ---- current detect ----
    // results reach only comparator
    if (r_r.st == ST_CD && cd_res_valid_in)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        mag = cd_res_in[i][23] ? 24'(-cd_res_in[i]) : cd_res_in[i];
        if (en[i] && mag > r_r.thr_reg && r_r.cd_hits[i] != 8'hFF)
        begin
          r_nxt.cd_hits[i] = r_r.cd_hits[i] + 8'h01;
        end
      end
      r_nxt.cd_samp = r_r.cd_samp + 12'h001;
      need = 8'(r_r.cfg_reg[CFG_CD_NUM_LSB +: 3]) + 8'h01;
      for (int i = 0; i < NCH; i++)
      begin
        met[i] = en[i] && (r_nxt.cd_hits[i] >= need);
      end
      if (r_r.cfg_reg[CFG_DETECT_ALL_CHANNELS])
      begin
        det = (|en) && ((met | ~en) == '1);
      end
      else
      begin
        det = |met;
      end
      if (det)
      begin
        r_nxt.st = ST_STBY;
        r_nxt.flag_n = 1'b0;
        r_nxt.flag_cnt = 8'(FLAG_LOW_CYC);
      end
      else if (r_nxt.cd_samp >= amr_cd_len(r_r.cfg_reg[CFG_CD_LEN_LSB +: 3]))
      begin
        r_nxt.cd_samp = 12'h000;
        r_nxt.cd_hits = '0;
      end
    end

    // no result escapes into standby or pin reset on the leaving edge
    if (r_nxt.st != ST_RUN)
    begin
      r_nxt.strobe = 1'b0;
    end

    // ---- flag pin ----
    if (r_nxt.strobe)
    begin
      r_nxt.flag_n = 1'b0;
      r_nxt.flag_cnt = 8'(FLAG_LOW_CYC);
    end
    else if (r_r.st != ST_POR && r_r.flag_cnt != 8'h00)
    begin
      r_nxt.flag_cnt = r_r.flag_cnt - 8'h01;
      if (r_r.flag_cnt == 8'h01)
      begin
        r_nxt.flag_n = 1'b1;
      end
    end

    // ---- register port ----
    r_nxt.rdata = 16'h0000;
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        REG_CLOCK: r_nxt.rdata = r_r.clock_reg;
        REG_CFG: r_nxt.rdata = r_r.cfg_reg;
        REG_THR_UP: r_nxt.rdata = r_r.thr_reg[23:8];
        REG_THR_LO: r_nxt.rdata = {8'h00, r_r.thr_reg[7:0]};
        REG_STATUS: r_nxt.rdata = {9'h000, r_r.nres, r_r.swap, r_r.settle, r_r.st};
        default: r_nxt.rdata = 16'h0000;
      endcase
    end
    if (bus_in.wr)
    begin
      case (bus_in.addr)
        REG_CLOCK: r_nxt.clock_reg = bus_in.wdata;
        REG_CFG: r_nxt.cfg_reg = bus_in.wdata;
        REG_THR_UP: r_nxt.thr_reg[23:8] = bus_in.wdata;
        REG_THR_LO: r_nxt.thr_reg[7:0] = bus_in.wdata[7:0];
        default: ;
      endcase
    end

    // ---- soft reset ----
    // defaults on every reset
    if (do_reset)
    begin
      if (r_r.st != ST_PINRST && r_nxt.st != ST_PINRST)
      begin
        r_nxt.st = ST_RUN;
      end
      r_nxt.clock_reg = CLOCK_RST;
      r_nxt.cfg_reg = CFG_RST;
      r_nxt.thr_reg = THR_RST;
      r_nxt.pcnt = 20'h00000;
      r_nxt.settle = 1'b0;
      r_nxt.nres = 2'h0;
      r_nxt.swap = 1'b0;
      r_nxt.strobe = 1'b0;
      r_nxt.flag_n = 1'b1;
      r_nxt.flag_cnt = 8'h00;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      // power-on: flag held low until settled
      r_r <= '0;
      r_r.st <= ST_POR;
      // idle pin levels: deselected, clock low, so no false edge
      r_r.sy1 <= 4'hB;
      r_r.sy2 <= 4'hB;
      r_r.clock_reg <= CLOCK_RST;
      r_r.cfg_reg <= CFG_RST;
      r_r.thr_reg <= THR_RST;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata_out = r_r.rdata;
  assign new_result_flag_n_out = r_r.flag_n;
  assign result_strobe_out = r_r.strobe;
  assign fast_filter_out = (r_r.nres < 2'h2) && !r_r.cfg_reg[CFG_GC_EN];
  assign swap_polarity_out = r_r.swap;
  assign phase_cal_off_out = r_r.cfg_reg[CFG_GC_EN];
  assign test_sig_block_out = r_r.cfg_reg[CFG_GC_EN];
  assign standby_out = (r_r.st == ST_STBY) || (r_r.st == ST_CD);
  assign cd_active_out = (r_r.st == ST_CD);
  assign channel_enable_out = (r_r.st == ST_RUN) ? r_r.clock_reg[NCH-1:0] : '0;
  assign power_level_out = r_r.clock_reg[CLK_PWR_LSB + 1] ? PWR_HR :
                           (r_r.clock_reg[CLK_PWR_LSB] ? PWR_LP : PWR_VLP);

endmodule // amr_ctrl
`default_nettype wire

// *** verilog/amr_pkg.sv ***
package amr_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NCH = 6;
  localparam int WORD_BITS = 24;
  localparam int FRAME_WORDS = 8;
  localparam int CLK_NS = 25;
  // ----------------------------------------
  // register indices and fields
  // ----------------------------------------
  localparam logic [3:0] REG_CLOCK = 4'h0;
  localparam logic [3:0] REG_CFG = 4'h1;
  localparam logic [3:0] REG_THR_UP = 4'h2;
  localparam logic [3:0] REG_THR_LO = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CLK_PWR_LSB = 8;
  localparam int CFG_GC_EN = 4;
  localparam int CFG_DETECT_MODE_ENABLE = 5;
  localparam int CFG_DETECT_ALL_CHANNELS = 6;
  localparam int CFG_CD_LEN_LSB = 8;
  localparam int CFG_CD_NUM_LSB = 12;
  localparam logic [15:0] CLOCK_RST = 16'h023F;
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [23:0] THR_RST = 24'h000000;
  // ----------------------------------------
  // serial commands
  // ----------------------------------------
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_STANDBY = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP = 16'h0033;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int T_RSL_NS = 2000;
  localparam int RSL_CYC = (T_RSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_POR_NS = 250000;
  localparam int POR_CYC = (T_POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_FLAG_LOW_NS = 500;
  localparam int FLAG_LOW_CYC = T_FLAG_LOW_NS / CLK_NS;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {ST_POR, ST_PINRST, ST_RUN, ST_STBY, ST_CD} amr_state_t;
  typedef enum logic [1:0] {PWR_VLP, PWR_LP, PWR_HR} amr_pwr_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } amr_bus_t;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } amr_ser_t;
  // detect pass length per code
  function automatic logic [11:0] amr_cd_len(input logic [2:0] c);
    case (c)
      3'h0: amr_cd_len = 12'h080;
      3'h1: amr_cd_len = 12'h100;
      3'h2: amr_cd_len = 12'h200;
      3'h3: amr_cd_len = 12'h300;
      3'h4: amr_cd_len = 12'h400;
      3'h5: amr_cd_len = 12'h600;
      3'h6: amr_cd_len = 12'h800;
      default: amr_cd_len = 12'hE00;
    endcase
  endfunction
endpackage
